//--- rtl/eid_pkg.sv
// Constants shared by the external interrupt detect and response logic
// Operation
// - Each external input has its own trigger-select bit in the control register.
// - Control register bits 7..0: ovf1, run1, ovf0, run0, req1, trig1, req0, trig0.
// - Trigger-select bit zero makes that external interrupt level activated.
// - Level mode latches a low pin at S5, sets the request flag at S3.
// - Level mode clears the pin-derived request flag at S6 of every machine cycle.
// - Trigger-select bit one makes that external interrupt edge activated.
// - Edge mode latches low at S5, passes to a second stage, detects the fall.
// - Edge flip-flop sets the request flag at S3 and clears at S4.
// - Edge mode ignores new requests until the first stage has seen high again.
// - A request during an ordinary instruction is vectored right after that instruction.
// - A request during an enable or priority write waits one further instruction.
// - Merely reading the enable or priority register does not defer vectoring.
// - After return from handler, one main instruction executes before the next vector.
// - If that first instruction writes enable or priority, two instructions execute first.
// - Vectors are 0003h, 000Bh, 0013h, 001Bh, 0023h, 002Bh per source order.
// - An interrupt is taken only with its own enable and the global enable set.
// - Equal-level simultaneous requests prefer ext0, timer0, ext1, timer1, serial, timer2.
// - High-priority requests preempt low handlers; nothing preempts high; disable bit removes levels.
`default_nettype none

package eid_pkg;
  localparam int           ADR_W       = 8;
  localparam int           DAT_W       = 32;
  localparam int           SEL_W       = 4;
  localparam int           SRC_N       = 6;
  localparam int           SRC_W       = 3;
  localparam int           PH_W        = 4;
  localparam int           EXT_N       = 2;

  // Register byte addresses
  localparam logic [7:0]   OFF_TIMER_AND_EXT_INT_CONTROL    = 8'h88;
  localparam logic [7:0]   OFF_IEN     = 8'hA8;
  localparam logic [7:0]   OFF_IPRI    = 8'hB8;
  localparam logic [7:0]   OFF_STAT    = 8'hC0;

  // Control register fields; ext channel n uses bits 2n and 2n+1
  localparam int           BIT_TRIG0   = 0;
  localparam int           BIT_REQ0    = 1;
  localparam int           EXT_STRIDE  = 2;
  localparam int           BIT_RUN0    = 4;
  localparam int           BIT_OVF0    = 5;
  localparam int           BIT_RUN1    = 6;
  localparam int           BIT_OVF1    = 7;

  // Enable and priority register fields
  localparam int           BIT_GIE     = 7;
  localparam int           BIT_PDIS    = 7;
  localparam int           BIT_RSV     = 6;
  localparam logic [7:0]   RSV_MASK    = 8'h40;

  localparam logic [7:0]   RST_TIMER_AND_EXT_INT_CONTROL    = 8'h00;
  localparam logic [7:0]   RST_IEN     = 8'h00;
  localparam logic [7:0]   RST_IPRI    = 8'h00;

  // Machine cycle: twelve oscillator periods, states S1..S6 two periods each
  localparam int           OSC_PER_MC  = 12;
  localparam logic [PH_W-1:0] PH_LAST    = PH_W'(OSC_PER_MC - 1);
  localparam logic [PH_W-1:0] PH_S3      = 4'h4;
  localparam logic [PH_W-1:0] PH_S3_LATE = 4'h5;
  localparam logic [PH_W-1:0] PH_S4      = 4'h6;
  localparam logic [PH_W-1:0] PH_S5      = 4'h8;
  localparam logic [PH_W-1:0] PH_S6      = 4'hA;

  // Source order doubles as fixed preference order
  localparam logic [SRC_W-1:0] SRC_EXT0 = 3'h0;
  localparam logic [SRC_W-1:0] SRC_TMR0 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 3'h2;
  localparam logic [SRC_W-1:0] SRC_TMR1 = 3'h3;
  localparam logic [SRC_W-1:0] SRC_SER  = 3'h4;
  localparam logic [SRC_W-1:0] SRC_TMR2 = 3'h5;

  localparam logic [15:0]  VEC_BASE    = 16'h0003;
  localparam logic [15:0]  VEC_STEP    = 16'h0008;
endpackage : eid_pkg

`default_nettype wire

//--- rtl/eid_pin_detect.sv
// Level and falling-edge detector for one external interrupt pin
`default_nettype none

module eid_pin_detect
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Pin and mode
  input  wire logic                     pin_n,
  input  wire logic                     edge_mode,
  input  wire logic [eid_pkg::PH_W-1:0] ph,
  // Flag requests
  output logic                          set_o,
  output logic                          clr_o
);
  import eid_pkg::*;

  logic lvl_r, lvl_nxt;
  logic st1_r, st1_nxt;
  logic st2_r, st2_nxt;
  logic rs_r,  rs_nxt;

  always_comb
  begin
    lvl_nxt = lvl_r;
    st1_nxt = st1_r;
    st2_nxt = st2_r;
    rs_nxt  = rs_r;
    if (ph == PH_S5)
    begin
      lvl_nxt = ~pin_n;
      st1_nxt = ~pin_n;
    end
    if (ph == PH_S3)
    begin
      st2_nxt = st1_r;
      // A new fall needs the first stage to have seen high in between
      if (st1_r && !st2_r)
      begin
        rs_nxt = 1'b1;
      end
    end
    if (ph == PH_S4)
    begin
      rs_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lvl_r <= 1'b0;
      st1_r <= 1'b0;
      st2_r <= 1'b0;
      rs_r  <= 1'b0;
    end
    else
    begin
      lvl_r <= lvl_nxt;
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
      rs_r  <= rs_nxt;
    end
  end

  assign set_o = edge_mode ? (rs_r && ph == PH_S3_LATE) : (lvl_r && ph == PH_S3);
  assign clr_o = !edge_mode && ph == PH_S6;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rs_clear_s4: assert property (ph == PH_S4 |=> !rs_r)
    else $error("edge flip-flop not cleared at S4");
  a_level_set_s3: assert property (!edge_mode && ph == PH_S3 && lvl_r |-> set_o)
    else $error("level latch did not set flag at S3");
  a_edge_needs_high: assert property (ph == PH_S3 && st2_r |=> !rs_r)
    else $error("edge flip-flop set without a high phase");
endmodule : eid_pin_detect

`default_nettype wire

//--- rtl/eid_irq_ctrl.sv
// External interrupt detection, flag register and vector call sequencing
`default_nettype none

module eid_irq_ctrl
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // Wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [eid_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [eid_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [eid_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [eid_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  // External interrupt pins, active low
  input  wire logic                        ext_irq0_pin_n,
  input  wire logic                        ext_irq1_pin_n,
  // Other request sources
  input  wire logic                        counter0_ovf_evt,
  input  wire logic                        counter1_ovf_evt,
  input  wire logic                        ser_req,
  input  wire logic                        tmr2_req,
  // Instruction sequencer
  input  wire logic                        instr_done,
  input  wire logic                        instr_ie_ip_wr,
  input  wire logic                        instr_return_from_handler,
  // Vector call
  output logic                             vec_call,
  output logic      [15:0]                 vec_addr,
  output logic      [eid_pkg::SRC_W-1:0]   vec_src,
  // Counter run controls
  output logic                             counter0_run,
  output logic                             counter1_run
);
  import eid_pkg::*;

  logic [PH_W-1:0]  ph_r, ph_nxt;
  logic [7:0]       timer_and_ext_int_control_r, timer_and_ext_int_control_nxt;
  logic [7:0]       ien_r, ien_nxt;
  logic [7:0]       ipri_r, ipri_nxt;
  logic             ack_r, ack_nxt;
  logic [DAT_W-1:0] rdat_r, rdat_nxt;
  logic             manip_r, manip_nxt;
  logic             act_lo_r, act_lo_nxt;
  logic             act_hi_r, act_hi_nxt;
  logic             call_r, call_nxt;
  logic [15:0]      addr_r, addr_nxt;
  logic [SRC_W-1:0] src_r, src_nxt;

  logic [EXT_N-1:0] det_set;
  logic [EXT_N-1:0] det_clr;
  logic [EXT_N-1:0] pins_n;
  logic             wb_req;
  logic             wb_wr;
  logic [SRC_N-1:0] req;
  logic [SRC_N-1:0] elig;
  logic [SRC_N-1:0] hi_req;
  logic [SRC_N-1:0] cand;
  logic             pdis;
  logic             take;
  logic             pick_hi;
  logic [SRC_W-1:0] pick;

  assign pins_n = {ext_irq1_pin_n, ext_irq0_pin_n};

  generate
    for (genvar ch = 0; ch < EXT_N; ch++)
    begin : g_ext
      eid_pin_detect u_det
      (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_n     (pins_n[ch]),
        .edge_mode (timer_and_ext_int_control_r[BIT_TRIG0 + EXT_STRIDE * ch]),
        .ph        (ph_r),
        .set_o     (det_set[ch]),
        .clr_o     (det_clr[ch])
      );
    end
  endgenerate

  // Request gathering and selection
  always_comb
  begin
    req  = {tmr2_req, ser_req, timer_and_ext_int_control_r[BIT_OVF1], timer_and_ext_int_control_r[BIT_REQ0 + EXT_STRIDE],
            timer_and_ext_int_control_r[BIT_OVF0], timer_and_ext_int_control_r[BIT_REQ0]};
    pdis = ipri_r[BIT_PDIS];
    elig = req & ien_r[SRC_N-1:0] & {SRC_N{ien_r[BIT_GIE]}};
    hi_req = elig & ipri_r[SRC_N-1:0];
    if (pdis)
    begin
      cand = elig;
    end
    else if (act_hi_r)
    begin
      cand = '0;
    end
    else if (act_lo_r || (|hi_req))
    begin
      cand = hi_req;
    end
    else
    begin
      cand = elig;
    end
    pick = '0;
    for (int i = SRC_N - 1; i >= 0; i--)
    begin
      if (cand[i])
      begin
        pick = SRC_W'(i);
      end
    end
    pick_hi = ipri_r[pick];
    take = instr_done && (|cand) && !instr_ie_ip_wr && !manip_r && !instr_return_from_handler;
  end

  // Phase, registers, bus and call sequencing
  always_comb
  begin
    ph_nxt     = (ph_r == PH_LAST) ? '0 : PH_W'(ph_r + 1'b1);
    wb_req     = wb_cyc_i && wb_stb_i && !ack_r;
    wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
    ack_nxt    = wb_req;
    rdat_nxt   = rdat_r;
    timer_and_ext_int_control_nxt   = timer_and_ext_int_control_r;
    ien_nxt    = ien_r;
    ipri_nxt   = ipri_r;
    manip_nxt  = manip_r;
    act_lo_nxt = act_lo_r;
    act_hi_nxt = act_hi_r;
    call_nxt   = take;
    addr_nxt   = addr_r;
    src_nxt    = src_r;

    if (wb_req && !wb_we_i)
    begin
      if (wb_adr_i == OFF_TIMER_AND_EXT_INT_CONTROL)
      begin
        rdat_nxt = DAT_W'(timer_and_ext_int_control_r);
      end
      else if (wb_adr_i == OFF_IEN)
      begin
        rdat_nxt = DAT_W'(ien_r | RSV_MASK);
      end
      else if (wb_adr_i == OFF_IPRI)
      begin
        rdat_nxt = DAT_W'(ipri_r | RSV_MASK);
      end
      else if (wb_adr_i == OFF_STAT)
      begin
        rdat_nxt = DAT_W'({manip_r, act_hi_r, act_lo_r, 1'b0, ph_r});
      end
      else
      begin
        rdat_nxt = '0;
      end
    end

    if (wb_wr)
    begin
      if (wb_adr_i == OFF_TIMER_AND_EXT_INT_CONTROL)
      begin
        timer_and_ext_int_control_nxt = wb_dat_i[7:0];
      end
      else if (wb_adr_i == OFF_IEN)
      begin
        ien_nxt   = wb_dat_i[7:0] & ~RSV_MASK;
        manip_nxt = 1'b1;
      end
      else if (wb_adr_i == OFF_IPRI)
      begin
        ipri_nxt  = wb_dat_i[7:0] & ~RSV_MASK;
        manip_nxt = 1'b1;
      end
    end

    // A bus write to enable or priority counts toward the instruction in flight
    if (instr_done && !(wb_wr && (wb_adr_i == OFF_IEN || wb_adr_i == OFF_IPRI)))
    begin
      manip_nxt = 1'b0;
    end

    // Hardware clears first, then sets, so an arriving event wins
    if (take && pick == SRC_TMR0)
    begin
      timer_and_ext_int_control_nxt[BIT_OVF0] = 1'b0;
    end
    if (take && pick == SRC_TMR1)
    begin
      timer_and_ext_int_control_nxt[BIT_OVF1] = 1'b0;
    end
    for (int ch = 0; ch < EXT_N; ch++)
    begin
      if (det_clr[ch])
      begin
        timer_and_ext_int_control_nxt[BIT_REQ0 + EXT_STRIDE * ch] = 1'b0;
      end
      if (take && timer_and_ext_int_control_r[BIT_TRIG0 + EXT_STRIDE * ch] && pick == SRC_W'(EXT_STRIDE * ch))
      begin
        timer_and_ext_int_control_nxt[BIT_REQ0 + EXT_STRIDE * ch] = 1'b0;
      end
      if (det_set[ch])
      begin
        timer_and_ext_int_control_nxt[BIT_REQ0 + EXT_STRIDE * ch] = 1'b1;
      end
    end
    if (counter0_ovf_evt)
    begin
      timer_and_ext_int_control_nxt[BIT_OVF0] = 1'b1;
    end
    if (counter1_ovf_evt)
    begin
      timer_and_ext_int_control_nxt[BIT_OVF1] = 1'b1;
    end

    // In-service levels
    if (instr_done && instr_return_from_handler)
    begin
      if (act_hi_r)
      begin
        act_hi_nxt = 1'b0;
      end
      else
      begin
        act_lo_nxt = 1'b0;
      end
    end
    if (take)
    begin
      addr_nxt = 16'(VEC_BASE + 16'(pick) * VEC_STEP);
      src_nxt  = pick;
      if (!pdis && pick_hi)
      begin
        act_hi_nxt = 1'b1;
      end
      else if (!pdis)
      begin
        act_lo_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ph_r     <= '0;
      timer_and_ext_int_control_r   <= RST_TIMER_AND_EXT_INT_CONTROL;
      ien_r    <= RST_IEN;
      ipri_r   <= RST_IPRI;
      ack_r    <= 1'b0;
      rdat_r   <= '0;
      manip_r  <= 1'b0;
      act_lo_r <= 1'b0;
      act_hi_r <= 1'b0;
      call_r   <= 1'b0;
      addr_r   <= '0;
      src_r    <= '0;
    end
    else
    begin
      ph_r     <= ph_nxt;
      timer_and_ext_int_control_r   <= timer_and_ext_int_control_nxt;
      ien_r    <= ien_nxt;
      ipri_r   <= ipri_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      manip_r  <= manip_nxt;
      act_lo_r <= act_lo_nxt;
      act_hi_r <= act_hi_nxt;
      call_r   <= call_nxt;
      addr_r   <= addr_nxt;
      src_r    <= src_nxt;
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = rdat_r;
  assign vec_call     = call_r;
  assign vec_addr     = addr_r;
  assign vec_src      = src_r;
  assign counter0_run = timer_and_ext_int_control_r[BIT_RUN0];
  assign counter1_run = timer_and_ext_int_control_r[BIT_RUN1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_no_call_manip: assert property (instr_done && instr_ie_ip_wr |=> !vec_call)
    else $error("vector called after enable or priority write");
  a_no_call_return_from_handler: assert property (instr_done && instr_return_from_handler |=> !vec_call)
    else $error("vector called right at return from handler");
  a_call_prompt: assert property (instr_done && !instr_ie_ip_wr && !instr_return_from_handler
                                  && !manip_r && (|cand) |=> vec_call)
    else $error("pending request not vectored after instruction");
  a_call_needs_gie: assert property (vec_call |-> $past(ien_r[BIT_GIE]))
    else $error("vector called with global enable clear");
  a_vec_addr_map: assert property (vec_call |->
                                   vec_addr == 16'(VEC_BASE + 16'(vec_src) * VEC_STEP))
    else $error("vector address does not match source");
  a_hi_not_preempt: assert property (act_hi_r && !pdis |=> !vec_call)
    else $error("high priority handler was preempted");
  a_pref_order: assert property (vec_call |->
                                 ($past(cand) & ((6'h01 << vec_src) - 6'h01)) == 6'h00)
    else $error("a preferred request was passed over");
  a_level_clear_s6: assert property (ph_r == PH_S6 && !timer_and_ext_int_control_r[BIT_TRIG0] && !wb_wr
                                     |=> !timer_and_ext_int_control_r[BIT_REQ0])
    else $error("level request flag not cleared at S6");

  c_any_call: cover property (vec_call);
  c_nested_hi: cover property (act_lo_r && vec_call && act_hi_r);
  c_deferred: cover property (instr_done && instr_ie_ip_wr && (|cand) ##[1:40] vec_call);
  c_edge_call: cover property (vec_call && vec_src == SRC_EXT0 && timer_and_ext_int_control_r[BIT_TRIG0]);
endmodule : eid_irq_ctrl

`default_nettype wire

//--- tb/eid_pin_src.sv
// Model of the external source driving one active-low interrupt pin
`default_nettype none

module eid_pin_src
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Requests from the bench
  input  wire logic fall,
  input  wire logic keep,
  // Pin, pulled up when released
  output logic      pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic       pend_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_n  <= 1'b1;
      cnt_r  <= 4'h0;
      pend_r <= 1'b0;
    end
    else
    begin
      if (fall)
        pend_r <= 1'b1;
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      else if (pin_n && (pend_r || fall))
      begin
        pin_n  <= 1'b0;
        cnt_r  <= 4'hB;
        pend_r <= 1'b0;
      end
      else if (!pin_n && !keep)
      begin
        pin_n <= 1'b1;
        cnt_r <= 4'hB;
      end
    end
  end
endmodule : eid_pin_src

`default_nettype wire

//--- tb/tb_ext_interrupt_detect_response.sv
// Self-checking bench for the external interrupt detect and response block
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end

module tb_ext_interrupt_detect_response;
  timeunit 1ns;
  timeprecision 1ps;
  import eid_pkg::*;
  localparam logic [2:0] NC = 3'h7;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic [DAT_W-1:0] rd;
  logic             ack;
  logic             pin0_n;
  logic             pin1_n;
  logic             ovf0 = 1'b0;
  logic             ovf1 = 1'b0;
  logic             sreq = 1'b0;
  logic             t2req = 1'b0;
  logic [SEL_W-1:0] sel = 4'hF;
  logic             done = 1'b0;
  logic             iew = 1'b0;
  logic             return_from_handler = 1'b0;
  logic             fall0 = 1'b0;
  logic             fall1 = 1'b0;
  logic             keep0 = 1'b0;
  logic             vcall;
  logic [15:0]      vaddr;
  logic [SRC_W-1:0] vsrc;
  logic             run0;
  logic             run1;
  logic             seen;
  int               fails = 0;
  int               cmp_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  eid_irq_ctrl dut
  (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq0_pin_n(pin0_n), .ext_irq1_pin_n(pin1_n), .counter0_ovf_evt(ovf0),
    .counter1_ovf_evt(ovf1), .ser_req(sreq), .tmr2_req(t2req), .instr_done(done),
    .instr_ie_ip_wr(iew), .instr_return_from_handler(return_from_handler), .vec_call(vcall), .vec_addr(vaddr),
    .vec_src(vsrc), .counter0_run(run0), .counter1_run(run1)
  );
  eid_pin_src src0 (.sys_clk(sys_clk), .rst(rst), .fall(fall0), .keep(keep0), .pin_n(pin0_n));
  eid_pin_src src1 (.sys_clk(sys_clk), .rst(rst), .fall(fall1), .keep(1'b0), .pin_n(pin1_n));

  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    @(posedge sys_clk);
    while (ack !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    `CHK("ack", 1'b1, ack)
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK("register", {24'h0, e}, rd)
  endtask : rchk

  task automatic step(input logic w, input logic r, input logic [2:0] es);
    @(posedge sys_clk);
    done <= 1'b1;
    iew  <= w;
    return_from_handler <= r;
    @(posedge sys_clk);
    done <= 1'b0;
    iew  <= 1'b0;
    return_from_handler <= 1'b0;
    @(posedge sys_clk);
    `CHK("vec_call", es != NC, vcall)
    if (es != NC)
    begin
      `CHK("vec_src", es, vsrc)
      `CHK("vec_addr", VEC_BASE + VEC_STEP * 16'(es), vaddr)
    end
  endtask : step

  task automatic fall(input logic k, input logic [1:0] which, input int n);
    @(posedge sys_clk);
    keep0 <= k;
    fall0 <= which[0];
    fall1 <= which[1];
    @(posedge sys_clk);
    fall0 <= 1'b0;
    fall1 <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : fall

  initial
  begin
    #100000;
    fails++;
    final_report();
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h00);
    rchk(OFF_IEN, 8'h40);
    rchk(OFF_IPRI, 8'h40);
    rchk(8'h10, 8'h00);
    wb(1'b1, OFF_TIMER_AND_EXT_INT_CONTROL, 8'h50);
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h50);
    `CHK("runs", 2'b11, {run1, run0})
    sel <= 4'h0;
    wb(1'b1, OFF_TIMER_AND_EXT_INT_CONTROL, 8'hFF);
    sel <= 4'hF;
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h50);
    @(posedge sys_clk);
    ovf0 <= 1'b1;
    ovf1 <= 1'b1;
    @(posedge sys_clk);
    ovf0 <= 1'b0;
    ovf1 <= 1'b0;
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'hF0);
    wb(1'b1, OFF_IEN, 8'h82);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, SRC_TMR0);
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'hD0);
    step(1'b0, 1'b1, NC);
    $display("test registers done");
    wb(1'b1, OFF_TIMER_AND_EXT_INT_CONTROL, 8'h05);
    fall(1'b1, 2'b01, 30);
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h07);
    step(1'b0, 1'b0, NC);
    wb(1'b1, OFF_TIMER_AND_EXT_INT_CONTROL, 8'h05);
    repeat (30) @(posedge sys_clk);
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h05);
    fall(1'b0, 2'b00, 30);
    fall(1'b1, 2'b01, 30);
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h07);
    wb(1'b1, OFF_IEN, 8'h81);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, SRC_EXT0);
    keep0 <= 1'b0;
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h05);
    $display("test edge done");
    fall(1'b0, 2'b01, 30);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b1, NC);
    step(1'b0, 1'b0, SRC_EXT0);
    fall(1'b0, 2'b01, 30);
    step(1'b0, 1'b1, NC);
    step(1'b1, 1'b0, NC);
    step(1'b0, 1'b0, SRC_EXT0);
    step(1'b0, 1'b1, NC);
    fall(1'b0, 2'b01, 30);
    rchk(OFF_IEN, 8'hC1);
    step(1'b0, 1'b0, SRC_EXT0);
    step(1'b0, 1'b1, NC);
    $display("test return done");
    wb(1'b1, OFF_IEN, 8'h85);
    fall(1'b0, 2'b11, 30);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, SRC_EXT0);
    wb(1'b1, OFF_IPRI, 8'h04);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, SRC_EXT1);
    wb(1'b0, OFF_STAT, 8'h00);
    `CHK("status", 4'h6, rd[7:4])
    fall(1'b0, 2'b01, 30);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b1, NC);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b1, NC);
    step(1'b0, 1'b0, SRC_EXT0);
    step(1'b0, 1'b1, NC);
    wb(1'b1, OFF_IPRI, 8'h80);
    wb(1'b0, OFF_STAT, 8'h00);
    `CHK("status", 4'h8, rd[7:4])
    fall(1'b0, 2'b01, 30);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, SRC_EXT0);
    fall(1'b0, 2'b01, 30);
    step(1'b0, 1'b0, SRC_EXT0);
    wb(1'b1, OFF_IEN, 8'hB8);
    @(posedge sys_clk);
    ovf1  <= 1'b1;
    sreq  <= 1'b1;
    t2req <= 1'b1;
    @(posedge sys_clk);
    ovf1  <= 1'b0;
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, SRC_TMR1);
    step(1'b0, 1'b0, SRC_SER);
    sreq  <= 1'b0;
    step(1'b0, 1'b0, SRC_TMR2);
    t2req <= 1'b0;
    wb(1'b1, OFF_IEN, 8'h05);
    fall(1'b0, 2'b01, 30);
    step(1'b0, 1'b0, NC);
    step(1'b0, 1'b0, NC);
    $display("test priority done");
    wb(1'b1, OFF_TIMER_AND_EXT_INT_CONTROL, 8'h00);
    fall(1'b0, 2'b01, 0);
    seen = 1'b0;
    repeat (16)
    begin
      wb(1'b0, OFF_TIMER_AND_EXT_INT_CONTROL, 8'h00);
      if (rd[1] === 1'b1)
        seen = 1'b1;
    end
    `CHK("level flag", 1'b1, seen)
    repeat (30) @(posedge sys_clk);
    rchk(OFF_TIMER_AND_EXT_INT_CONTROL, 8'h00);
    $display("test level done");
    final_report();
  end
endmodule : tb_ext_interrupt_detect_response

`default_nettype wire
